// ---- hdl/vcw_vcrop.sv ----
// Purpose: vertical crop window per output port, APB slave, input FIFO
// Assumes: core clock is the pixel clock; video source is synchronous
// Notes: lines outside the window keep timing but lose pixel_valid
//
// The APB register port was decided locally.
`timescale 1ns/10ps
`default_nettype none

// Plain ring FIFO; full and empty come from an occupancy count
module vcw_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,               // Clock
    input wire logic arst_n_i,            // Async reset, active low
    input wire logic in_valid_i,          // Write request
    input wire logic [WIDTH-1:0] in_data_i, // Write data
    output logic in_ready_o,              // Not full
    output logic out_valid_o,             // Not empty
    output logic [WIDTH-1:0] out_data_o,  // Head word
    input wire logic out_ready_i          // Read accept
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic push, pop;

    // Handshakes; pop only when a word is really there
    assign in_ready_o = (count != DEPTH[AW:0]);
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // Pointer and count update, wrapping at DEPTH
    always_comb begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count = count;
        if (push) begin
            next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
        end
        if (pop) begin
            next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // Storage needs no reset; contents are ignored while empty
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end
endmodule

module vcw_vcrop #(
    parameter int DEPTH = vcw_pkg::FIFO_DEPTH
) (
    input wire logic core_clk_i,                        // Pixel clock
    input wire logic arst_n_i,                          // Async reset, low
    input wire logic psel_i,                            // APB select
    input wire logic penable_i,                         // APB enable
    input wire logic pwrite_i,                          // APB direction
    input wire logic [vcw_pkg::ADDR_W-1:0] paddr_i,     // APB address
    input wire logic [vcw_pkg::DATA_W-1:0] pwdata_i,    // APB write data
    input wire logic [3:0] pstrb_i,                     // APB byte strobes
    output logic [vcw_pkg::DATA_W-1:0] prdata_o,        // APB read data
    output logic pready_o,                              // APB ready
    output logic pslverr_o,                             // APB error
    input wire vcw_pkg::vcw_beat_t vid_i,               // Input beat
    input wire logic vid_valid_i,                       // Input valid
    output logic vid_ready_o,                           // Input ready
    output vcw_pkg::vcw_beat_t [vcw_pkg::NPORT-1:0] port_o, // Port beats
    output logic port_valid_o,                          // Port beats valid
    input wire logic port_ready_i                       // Ports accept
);
    localparam int NP = vcw_pkg::NPORT;
    localparam int PW = vcw_pkg::POS_W;

    // Settings per port, plus the shared port select and split mode
    logic [PW-1:0] first_line [NP];
    logic [PW-1:0] last_line [NP];
    logic [NP-1:0] crop_en;
    logic [PW-1:0] next_first_line [NP];
    logic [PW-1:0] next_last_line [NP];
    logic [NP-1:0] next_crop_en;
    logic port_sel, next_port_sel;
    logic split_mode, next_split_mode;
    logic [vcw_pkg::DATA_W-1:0] next_prdata;

    // Bus decode
    logic [vcw_pkg::IDX_W-1:0] idx;
    logic mapped, setup, wr_en, rd_port;
    logic [NP-1:0] wr_port;

    // Stream path
    vcw_pkg::vcw_beat_t fifo_beat;
    logic fifo_valid, fifo_ready, pop;
    logic [PW-1:0] line_cnt, next_line_cnt, beat_line;
    vcw_pkg::vcw_beat_t [NP-1:0] next_port;
    logic next_port_valid;

    assign idx = paddr_i[vcw_pkg::ADDR_W-1:2];
    assign mapped = (paddr_i[1:0] == 2'h0) &&
        (idx == vcw_pkg::IDX_FIRST_LO || idx == vcw_pkg::IDX_FIRST_HI ||
         idx == vcw_pkg::IDX_LAST_LO || idx == vcw_pkg::IDX_LAST_HI ||
         idx == vcw_pkg::IDX_CTRL || idx == vcw_pkg::IDX_STATUS);

    // Zero wait states; error only on access to an unmapped word or an unaligned address
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !mapped;
    assign setup = psel_i && !penable_i;
    assign wr_en = psel_i && penable_i && pwrite_i && mapped && pstrb_i[0];

    // Writes reach only the selected port in split mode, both otherwise
    always_comb begin
        for (int p = 0; p < NP; p++) begin
            wr_port[p] = split_mode ? (port_sel == p[0]) : 1'b1;
        end
    end
    // Readback shows port 0 unless split mode selects otherwise
    assign rd_port = split_mode ? port_sel : 1'b0;

    // Register writes; bits above each field are dropped
    always_comb begin
        next_first_line = first_line;
        next_last_line = last_line;
        next_crop_en = crop_en;
        next_port_sel = port_sel;
        next_split_mode = split_mode;
        for (int p = 0; p < NP; p++) begin
            if (wr_en && wr_port[p]) begin
                unique case (idx)
                    vcw_pkg::IDX_FIRST_LO: begin
                        next_first_line[p][7:0] = pwdata_i[7:0];
                    end
                    vcw_pkg::IDX_FIRST_HI: begin
                        next_first_line[p][12:8] = pwdata_i[4:0];
                    end
                    vcw_pkg::IDX_LAST_LO: begin
                        next_last_line[p][7:0] = pwdata_i[7:0];
                    end
                    vcw_pkg::IDX_LAST_HI: begin
                        next_last_line[p][12:8] = pwdata_i[4:0];
                    end
                    vcw_pkg::IDX_CTRL: begin
                        next_crop_en[p] = pwdata_i[vcw_pkg::CTRL_EN_BIT];
                    end
                    default: begin
                    end
                endcase
            end
        end
        if (wr_en && idx == vcw_pkg::IDX_CTRL) begin
            next_port_sel = pwdata_i[vcw_pkg::CTRL_SEL_BIT];
            next_split_mode = pwdata_i[vcw_pkg::CTRL_SPLIT_BIT];
        end
    end

    // Read data is captured in the setup cycle, ready for the access
    always_comb begin
        next_prdata = prdata_o;
        if (setup) begin
            next_prdata = '0;
            unique case (idx)
                vcw_pkg::IDX_FIRST_LO: begin
                    next_prdata[7:0] = first_line[rd_port][7:0];
                end
                vcw_pkg::IDX_FIRST_HI: begin
                    next_prdata[4:0] = first_line[rd_port][12:8];
                end
                vcw_pkg::IDX_LAST_LO: begin
                    next_prdata[7:0] = last_line[rd_port][7:0];
                end
                vcw_pkg::IDX_LAST_HI: begin
                    next_prdata[4:0] = last_line[rd_port][12:8];
                end
                vcw_pkg::IDX_CTRL: begin
                    next_prdata[vcw_pkg::CTRL_SEL_BIT] = port_sel;
                    next_prdata[vcw_pkg::CTRL_SPLIT_BIT] = split_mode;
                    next_prdata[vcw_pkg::CTRL_EN_BIT] = crop_en[rd_port];
                end
                vcw_pkg::IDX_STATUS: begin
                    next_prdata[PW-1:0] = line_cnt;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int p = 0; p < NP; p++) begin
                first_line[p] <= vcw_pkg::POS_RST;
                last_line[p] <= vcw_pkg::POS_RST;
            end
            crop_en <= '0;
            port_sel <= vcw_pkg::CTRL_RST;
            split_mode <= vcw_pkg::CTRL_RST;
            prdata_o <= '0;
        end else begin
            first_line <= next_first_line;
            last_line <= next_last_line;
            crop_en <= next_crop_en;
            port_sel <= next_port_sel;
            split_mode <= next_split_mode;
            prdata_o <= next_prdata;
        end
    end

    // Input buffer absorbs short stalls of the port sink
    vcw_fifo #(
        .WIDTH(vcw_pkg::BEAT_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .in_valid_i(vid_valid_i),
        .in_data_i(vid_i),
        .in_ready_o(vid_ready_o),
        .out_valid_o(fifo_valid),
        .out_data_o(fifo_beat),
        .out_ready_i(fifo_ready)
    );

    // Output stage refills when empty or when its beat is taken
    assign fifo_ready = !port_valid_o || port_ready_i;
    assign pop = fifo_valid && fifo_ready;

    // Frame start beat belongs to line 0 whatever the old count was
    assign beat_line = fifo_beat.sof ? '0 : line_cnt;

    // Line count steps after the last active pixel of each line
    always_comb begin
        next_line_cnt = line_cnt;
        if (pop) begin
            next_line_cnt = beat_line +
                PW'(fifo_beat.pixel_valid && fifo_beat.eol);
        end
    end

    // Window test per port; outside it the beat keeps its slot, no pixel
    always_comb begin
        next_port = port_o;
        next_port_valid = port_valid_o;
        if (fifo_ready) begin
            next_port_valid = fifo_valid;
        end
        if (pop) begin
            for (int p = 0; p < NP; p++) begin
                next_port[p] = fifo_beat;
                if (crop_en[p] &&
                    (beat_line < first_line[p] ||
                     beat_line > last_line[p])) begin
                    next_port[p].pixel_valid = 1'b0;
                    next_port[p].data = '0;
                end
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            line_cnt <= '0;
            port_o <= '0;
            port_valid_o <= 1'b0;
        end else begin
            line_cnt <= next_line_cnt;
            port_o <= next_port;
            port_valid_o <= next_port_valid;
        end
    end
endmodule

`default_nettype wire

// ---- hdl/vcw_pkg.sv ----
// Purpose: shared constants and carrier types for the vertical crop window
// Assumes: APB with 32-bit data, register index times four is the address
// Notes: two output ports, each with its own crop settings
package vcw_pkg;
    // Bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int IDX_W = 6;
    // Register indexes; byte address is index times four
    localparam logic [IDX_W-1:0] IDX_FIRST_LO = 6'h3A;
    localparam logic [IDX_W-1:0] IDX_FIRST_HI = 6'h3B;
    localparam logic [IDX_W-1:0] IDX_LAST_LO = 6'h3C;
    localparam logic [IDX_W-1:0] IDX_LAST_HI = 6'h3D;
    localparam logic [IDX_W-1:0] IDX_CTRL = 6'h30;
    localparam logic [IDX_W-1:0] IDX_STATUS = 6'h31;
    // Field layout
    localparam int POS_W = 13;
    localparam int LO_W = 8;
    localparam int HI_W = 5;
    localparam int CTRL_SEL_BIT = 0;
    localparam int CTRL_SPLIT_BIT = 1;
    localparam int CTRL_EN_BIT = 2;
    // Reset values
    localparam logic [POS_W-1:0] POS_RST = 13'h0000;
    localparam logic CTRL_RST = 1'h0;
    // Video stream
    localparam int PIX_W = 24;
    localparam int NPORT = 2;
    localparam int FIFO_DEPTH = 16;

    typedef struct packed {
        logic sof;              // First beat of a frame
        logic eol;              // Last active pixel of a line
        logic pixel_valid;      // Active pixel
        logic [PIX_W-1:0] data; // Pixel value
    } vcw_beat_t;

    localparam int BEAT_W = $bits(vcw_beat_t);
endpackage

// ---- tb/vcw_vcrop_monitor.sv ----
// Purpose: port-level checks for the vertical crop window
// Assumes: pready is constant high, prdata valid in access phase
// Notes: sees only the top ports; bound below the module
`timescale 1ns/10ps
`default_nettype none
module vcw_vcrop_monitor #(
    parameter int DEPTH = 16
) (
    input wire logic core_clk_i, // Clock
    input wire logic arst_n_i, // Reset
    input wire logic psel_i, // Select
    input wire logic penable_i, // Enable
    input wire logic pwrite_i, // Direction
    input wire logic [7:0] paddr_i, // Address
    input wire logic [31:0] prdata_o, // Read data
    input wire logic pslverr_o, // Error
    input wire vcw_pkg::vcw_beat_t [1:0] port_o, // Port beats
    input wire logic port_valid_o, // Beats valid
    input wire logic port_ready_i // Sink ready
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    // Access phase of a transfer
    logic acc;
    assign acc = psel_i && penable_i;
    a_out_hold: assert property (port_valid_o && !port_ready_i |=>
        port_valid_o && $stable(port_o)) else $error("beat dropped");
    a_blank_zero0: assert property (port_valid_o &&
        !port_o[0].pixel_valid |-> port_o[0].data == 24'h000000)
        else $error("port 0 blank carries data");
    a_blank_zero1: assert property (port_valid_o &&
        !port_o[1].pixel_valid |-> port_o[1].data == 24'h000000)
        else $error("port 1 blank carries data");
    a_ports_timing: assert property (port_valid_o |->
        {port_o[0].sof, port_o[0].eol} == {port_o[1].sof, port_o[1].eol})
        else $error("port timing differs");
    a_err_unmapped: assert property (acc && !(paddr_i inside
        {8'hE8, 8'hEC, 8'hF0, 8'hF4, 8'hC0, 8'hC4}) |-> pslverr_o)
        else $error("no error on unmapped address");
    a_err_mapped: assert property (acc && (paddr_i inside
        {8'hE8, 8'hEC, 8'hF0, 8'hF4}) |-> !pslverr_o)
        else $error("error on mapped address");
    a_hi_reserved: assert property (acc && !pwrite_i &&
        (paddr_i inside {8'hEC, 8'hF4}) |-> prdata_o[31:5] == 27'h0)
        else $error("reserved high bits set");
    a_lo_reserved: assert property (acc && !pwrite_i &&
        (paddr_i inside {8'hE8, 8'hF0}) |-> prdata_o[31:8] == 24'h0)
        else $error("low register upper bits set");
endmodule
bind vcw_vcrop vcw_vcrop_monitor #(.DEPTH(DEPTH)) mon_u (.core_clk_i,
    .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .prdata_o,
    .pslverr_o, .port_o, .port_valid_o, .port_ready_i);
`default_nettype wire

// ---- tb/vcw_vcrop_bench.sv ----
// Purpose: self-checking bench for the vertical crop window
// Assumes: DEPTH cut to 2 so random stalls fill the buffer
// Notes: drivers queue expectations, one monitor compares
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module vcw_vcrop_bench;
    logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic stall = 1, vid_valid = 0, port_ready = 1, pready, pslverr;
    logic vid_ready, port_valid;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rv, r, wv[4];
    logic [3:0] pstrb = 4'h0;
    vcw_pkg::vcw_beat_t vid = '0;
    vcw_pkg::vcw_beat_t [1:0] port, ev;
    logic [31:0] rd_q[$];
    logic [53:0] exp_q[$], pe;
    logic en_m[2] = '{0, 0};
    logic [12:0] fst[2], lst[2];
    int n_mismatch = 0, n_tests = 0, seed = 90493;
    localparam logic [7:0] RA[4] = '{8'hE8, 8'hEC, 8'hF0, 8'hF4};
    localparam logic [31:0] MK[4] = '{32'hFF, 32'h1F, 32'hFF, 32'h1F};
    vcw_vcrop #(.DEPTH(2)) dut_u (.core_clk_i(clk), .arst_n_i(arst_n),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .vid_i(vid), .vid_valid_i(vid_valid), .vid_ready_o(vid_ready),
        .port_o(port), .port_valid_o(port_valid),
        .port_ready_i(port_ready));
    always #20 clk = ~clk;
    // Random sink stalls keep the small buffer full at times
    always @(posedge clk) port_ready <= stall ? 1'($random(seed)) : 1'b1;
    // One APB transfer, held until pready is seen
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        psel <= 1; penable <= 0; pwrite <= w;
        paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge clk); penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 0; penable <= 0;
        // Idle edge so the next setup never reassigns psel in this step
        @(posedge clk);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e); apb(0, a, 32'h0, 4'hF);
    endtask
    // Window for the selected port, both bytes of both positions
    task win(input int p, input logic [12:0] f, input logic [12:0] l);
        apb(1, 8'hE8, {24'h0, f[7:0]}, 4'hF);
        apb(1, 8'hEC, {27'h0, f[12:8]}, 4'hF);
        apb(1, 8'hF0, {24'h0, l[7:0]}, 4'hF);
        apb(1, 8'hF4, {27'h0, l[12:8]}, 4'hF);
        fst[p] = f; lst[p] = l;
    endtask
    // Frame of nl lines, three active pixels each
    task frame(input int nl);
        vcw_pkg::vcw_beat_t b;
        for (int l = 0; l < nl; l++) for (int k = 0; k < 3; k++) begin
            b = {l == 0 && k == 0, k == 2, 1'b1, 24'($random(seed))};
            for (int p = 0; p < 2; p++) begin
                ev[p] = b;
                ev[p].pixel_valid = !en_m[p] || (l >= fst[p] && l <= lst[p]);
                if (!ev[p].pixel_valid) ev[p].data = 24'h000000;
            end
            exp_q.push_back(ev);
            vid <= b; vid_valid <= 1;
            do @(posedge clk); while (vid_ready !== 1'b1);
        end
        vid_valid <= 0;
        for (int i = 0; i < 400 && exp_q.size() != 0; i++) @(posedge clk);
    endtask
    // Output watcher: oldest note against what appears
    always @(posedge clk) if (arst_n) begin
        if (psel && penable && !pwrite) begin
            rv = rd_q.pop_front();
            `CHK(prdata, rv)
        end
        if (port_valid && port_ready) begin
            pe = exp_q.pop_front();
            `CHK(port, pe)
        end
    end
    task final_report;
        $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #(40 * 6000);
        n_mismatch++;
        final_report;
    end
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1;
        @(posedge clk);
        for (int i = 0; i < 4; i++) rd(RA[i], 32'h0);
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            wv[i] = r & MK[i];
            apb(1, RA[i], r, 4'hF);
            rd(RA[i], wv[i]);
        end
        apb(1, 8'hE8, 32'h55, 4'h0);
        rd(8'hE8, wv[0]);
        rd(8'hD0, 32'h0);
        $display("register test done");
        // Shared window, both ports cropped alike
        apb(1, 8'hC0, 32'h4, 4'hF);
        en_m = '{1, 1};
        win(0, 13'd2, 13'd4);
        fst[1] = 13'd2; lst[1] = 13'd4;
        frame(7);
        $display("crop test done");
        apb(1, 8'hC0, 32'h0, 4'hF);
        en_m = '{0, 0};
        frame(3);
        $display("bypass test done");
        // Split: port 1 gets its own window, port 0 keeps 2..4
        apb(1, 8'hC0, 32'h6, 4'hF);
        apb(1, 8'hC0, 32'h7, 4'hF);
        en_m = '{1, 1};
        win(1, 13'd5, 13'd6);
        rd(8'hE8, 32'h5);
        rd(8'hC0, 32'h7);
        frame(8);
        $display("split test done");
        // Eight lines counted; then a mid-run reset must clear port 1 too
        rd(8'hC4, 32'h8);
        arst_n <= 0;
        repeat (2) @(posedge clk);
        arst_n <= 1;
        @(posedge clk);
        apb(1, 8'hC0, 32'h3, 4'hF);
        rd(8'hE8, 32'h0);
        rd(8'hF0, 32'h0);
        rd(8'hC4, 32'h0);
        $display("reset test done");
        // Notes left unanswered mean lost beats or reads
        `CHK(exp_q.size() + rd_q.size(), 0)
        final_report;
    end
endmodule
`default_nettype wire
